// [core/address_breakpoint_unit.sv]
// Address breakpoint unit: APB registers, address compare, break sequencing toward the CPU.
//
// Contract
// [R1] With enable set, a full 16-bit address match raises a break request.
// [R2] On break the CPU gets the soft trap opcode and user or monitor vector.
// [R3] Break waits for instruction end, unless the match is on the final cycle.
// [R4] Writing one to the break-active bit triggers a break.
// [R5] Break-active is set by a match, reads zero otherwise, reset clears it.
// [R6] Handler software clears break-active by writing zero before leaving.
// [R7] Match enable is bit 7 of control register, read/write, reset clears it.
// [R8] Address high and low registers at FE0C and FE0D reset to zero.
// [R9] The return-from-trap instruction ends the break state.
// [R10] Timer counters are halted while a break is in progress.
// [R11] Watchdog held off during break when reset pin is at test voltage.
// [R12] Breaks stay active in wait mode and set exited-wait flag on wake.
// [R13] Exited-wait flag is bit 1, cleared by writing zero and by reset.
// [R14] In stop mode matching is inactive and registers are unchanged.
// [R15] Flags elsewhere clear during break only while clear enable is one.
// [R16] Handler may decrement the stacked return address when exited-wait is set.
// [R17] The break request is held pending until the CPU accepts it.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module address_breakpoint_unit
  import brk_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] cpuAddr,
  input  wire logic        cpuAddrValid,
  input  wire logic        instrLastCycle,
  input  wire logic        instrBoundary,
  input  wire logic        returnFromTrap,
  input  wire logic        waitMode,
  input  wire logic        stopMode,
  input  wire logic        monitorMode,
  input  wire logic        resetPinTestVoltage,
  output logic             breakRequest,
  output logic [7:0]       trapOpcode,
  output logic [15:0]      trapVector,
  output logic             breakInProgress,
  output logic             timerHalt,
  output logic             watchdogDisable,
  output logic             flagClearAllowed,
  output logic             irq
);

  brk_state_e state_q;
  logic [7:0]  addrHigh_q;
  logic [7:0]  addrLow_q;
  logic        matchEnable_q;
  logic        breakActive_q;
  logic        exitedWait_q;
  logic        flagClearEn_q;
  logic [2:0]  irqStatus_q;
  logic [2:0]  irqMask_q;
  logic        wasWaiting_q;
  logic        testVolt1_q;
  logic        testVolt2_q;
  logic        setup;
  logic        wrAcc;
  logic        rdAcc;
  logic        addrHit;
  logic        softBreak;
  logic        mapped;
  logic [7:0]  wByte;

  // Register offsets are word indices, so the byte address is four times the offset.
  // Only aligned words with the upper address bits clear select a register.
  function automatic logic isReg(input logic [31:0] a, input logic [15:0] r);
    isReg = (a[31:18] == 14'h0000) && (a[17:2] == r) && (a[1:0] == 2'b00);
  endfunction

  assign wByte = pwdata[7:0];
  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite && pstrb[0] && !pslverr;
  assign rdAcc = psel && penable && !pwrite;
  assign mapped = isReg(paddr, ADDR_SIM_BREAK_STATUS) || isReg(paddr, ADDR_BREAK_FLAG_CLR_CTRL)
               || isReg(paddr, ADDR_BKPT_ADDR_HIGH) || isReg(paddr, ADDR_BKPT_ADDR_LOW)
               || isReg(paddr, ADDR_BKPT_STATUS_CTRL) || isReg(paddr, ADDR_IRQ_STATUS)
               || isReg(paddr, ADDR_IRQ_MASK);

  // Zero wait states; unmapped addresses answer with an error and change nothing.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Matching is off in stop mode and when the enable bit is clear.
  assign addrHit = matchEnable_q && !stopMode && cpuAddrValid && (cpuAddr == {addrHigh_q, addrLow_q}); // [R1] [R14]
  assign softBreak = wrAcc && isReg(paddr, ADDR_BKPT_STATUS_CTRL) && wByte[BIT_BREAK_ACTIVE] && !breakActive_q; // [R4]

  always_ff @(posedge mclk) begin
    if (srst) begin
      addrHigh_q <= RESET_BYTE;
      addrLow_q  <= RESET_BYTE;
    end else if (wrAcc && isReg(paddr, ADDR_BKPT_ADDR_HIGH)) begin
      addrHigh_q <= wByte; // [R8]
    end else if (wrAcc && isReg(paddr, ADDR_BKPT_ADDR_LOW)) begin
      addrLow_q <= wByte; // [R8]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      matchEnable_q <= 1'b0;
      flagClearEn_q <= 1'b0;
    end else if (wrAcc && isReg(paddr, ADDR_BKPT_STATUS_CTRL)) begin
      matchEnable_q <= wByte[BIT_MATCH_ENABLE]; // [R7]
    end else if (wrAcc && isReg(paddr, ADDR_BREAK_FLAG_CLR_CTRL)) begin
      flagClearEn_q <= wByte[BIT_FLAG_CLEAR_EN]; // [R15]
    end
  end

  // A match sets the flag and wins over a clearing write in the same cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      breakActive_q <= 1'b0;
    end else if (addrHit || softBreak) begin
      breakActive_q <= 1'b1; // [R5] [R4]
    end else if (wrAcc && isReg(paddr, ADDR_BKPT_STATUS_CTRL) && !wByte[BIT_BREAK_ACTIVE]) begin
      breakActive_q <= 1'b0; // [R6]
    end
  end

  // Break sequencing toward the CPU.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (addrHit && instrLastCycle) begin
            state_q <= ST_BREAK; // [R3]
          end else if (addrHit || softBreak) begin
            state_q <= ST_PENDING; // [R17]
          end
        end
        ST_PENDING: begin
          if (instrBoundary) begin
            state_q <= ST_BREAK; // [R3] [R17]
          end
        end
        ST_BREAK: begin
          if (returnFromTrap) begin
            state_q <= ST_RUN; // [R9]
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Remembers whether the pending break started while the CPU was waiting.
  always_ff @(posedge mclk) begin
    if (srst) begin
      wasWaiting_q <= 1'b0;
    end else if (state_q == ST_RUN) begin
      wasWaiting_q <= waitMode;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      exitedWait_q <= 1'b0;
    end else if (state_q != ST_BREAK && breakRequest && (waitMode || wasWaiting_q) && instrBoundary) begin
      exitedWait_q <= 1'b1; // [R12]
    end else if (wrAcc && isReg(paddr, ADDR_SIM_BREAK_STATUS) && !wByte[BIT_EXITED_WAIT]) begin
      exitedWait_q <= 1'b0; // [R13]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      testVolt1_q <= 1'b0;
      testVolt2_q <= 1'b0;
    end else begin
      testVolt1_q <= resetPinTestVoltage;
      testVolt2_q <= testVolt1_q;
    end
  end

  logic [2:0] irqEvents;
  assign irqEvents = {(state_q != ST_BREAK) && breakRequest && (waitMode || wasWaiting_q) && instrBoundary,
                      softBreak, addrHit};

  // Sticky interrupt status, write one to clear; new events win over the clear.
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqStatus_q <= IRQ_RESET;
    end else if (wrAcc && isReg(paddr, ADDR_IRQ_STATUS)) begin
      irqStatus_q <= (irqStatus_q & ~wByte[2:0]) | irqEvents;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvents;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irqMask_q <= IRQ_RESET;
    end else if (wrAcc && isReg(paddr, ADDR_IRQ_MASK)) begin
      irqMask_q <= wByte[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (isReg(paddr, ADDR_SIM_BREAK_STATUS)) begin
        prdata[BIT_EXITED_WAIT] <= exitedWait_q;
      end else if (isReg(paddr, ADDR_BREAK_FLAG_CLR_CTRL)) begin
        prdata[BIT_FLAG_CLEAR_EN] <= flagClearEn_q;
      end else if (isReg(paddr, ADDR_BKPT_ADDR_HIGH)) begin
        prdata[7:0] <= addrHigh_q;
      end else if (isReg(paddr, ADDR_BKPT_ADDR_LOW)) begin
        prdata[7:0] <= addrLow_q;
      end else if (isReg(paddr, ADDR_BKPT_STATUS_CTRL)) begin
        prdata[BIT_MATCH_ENABLE] <= matchEnable_q;
        prdata[BIT_BREAK_ACTIVE] <= breakActive_q;
      end else if (isReg(paddr, ADDR_IRQ_STATUS)) begin
        prdata[2:0] <= irqStatus_q;
      end else if (isReg(paddr, ADDR_IRQ_MASK)) begin
        prdata[2:0] <= irqMask_q;
      end
    end
  end

  assign breakRequest = (state_q == ST_PENDING) || (state_q == ST_RUN && addrHit && instrLastCycle); // [R17] [R3]
  assign breakInProgress = (state_q == ST_BREAK);
  assign trapOpcode = SOFT_TRAP_OPCODE; // [R2]
  assign trapVector = monitorMode ? VEC_MONITOR : VEC_USER; // [R2]
  assign timerHalt = (state_q == ST_BREAK); // [R10]
  assign watchdogDisable = (state_q == ST_BREAK) && testVolt2_q; // [R11]
  assign flagClearAllowed = (state_q != ST_BREAK) || flagClearEn_q; // [R15]
  assign irq = |(irqStatus_q & irqMask_q);

  a_match_raises_req: assert property (@(posedge mclk) disable iff (srst) // [R1]
    (state_q == ST_RUN && addrHit) |-> (breakRequest) or (##1 breakRequest))
    else $error("Address match did not raise a break request.");
  a_pending_holds: assert property (@(posedge mclk) disable iff (srst) // [R17]
    (state_q == ST_PENDING && !instrBoundary) |=> breakRequest)
    else $error("Pending break request dropped before boundary.");
  a_last_cycle_now: assert property (@(posedge mclk) disable iff (srst) // [R3]
    (state_q == ST_RUN && addrHit && instrLastCycle) |=> state_q == ST_BREAK)
    else $error("Match on last cycle did not break at once.");
  a_soft_break: assert property (@(posedge mclk) disable iff (srst) // [R4]
    softBreak |=> breakActive_q && state_q != ST_RUN)
    else $error("Writing break-active did not start a break.");
  a_match_sets_flag: assert property (@(posedge mclk) disable iff (srst) // [R5]
    addrHit |=> breakActive_q)
    else $error("Match did not set break-active.");
  a_rti_ends_break: assert property (@(posedge mclk) disable iff (srst) // [R9]
    (state_q == ST_BREAK && returnFromTrap) |=> !timerHalt)
    else $error("Return from trap did not end the break.");
  a_timer_halted: assert property (@(posedge mclk) disable iff (srst) // [R10]
    $rose(breakInProgress) |-> timerHalt)
    else $error("Timers not halted during break.");
  a_stop_no_match: assert property (@(posedge mclk) disable iff (srst) // [R14]
    stopMode |-> !addrHit)
    else $error("Match logic active in stop mode.");
  a_flag_clear_gate: assert property (@(posedge mclk) disable iff (srst) // [R15]
    (breakInProgress && !flagClearEn_q) |-> !flagClearAllowed)
    else $error("Flag clearing allowed in break without enable.");
  a_watchdog_off: assert property (@(posedge mclk) disable iff (srst) // [R11]
    (breakInProgress && testVolt2_q) |-> watchdogDisable)
    else $error("Watchdog not held off at test voltage.");

  // A pending break enters the break state at the first instruction boundary.
  a_pending_to_break: assert property (@(posedge mclk) disable iff (srst) // [R3]
    (state_q == ST_PENDING && instrBoundary) |=> breakInProgress)
    else $error("Pending break did not start at the boundary.");

  a_vector_monitor: assert property (@(posedge mclk) disable iff (srst) // [R2]
    (breakInProgress && monitorMode) |-> trapVector == VEC_MONITOR)
    else $error("Monitor mode break used the wrong vector.");

  a_vector_user: assert property (@(posedge mclk) disable iff (srst) // [R2]
    (breakInProgress && !monitorMode) |-> trapVector == VEC_USER && trapOpcode == SOFT_TRAP_OPCODE)
    else $error("User mode break used the wrong vector or opcode.");

  a_enable_write: assert property (@(posedge mclk) disable iff (srst) // [R7]
    (wrAcc && isReg(paddr, ADDR_BKPT_STATUS_CTRL)) |=> matchEnable_q == $past(wByte[BIT_MATCH_ENABLE]))
    else $error("Match enable did not take the written value.");

  a_addr_high_write: assert property (@(posedge mclk) disable iff (srst) // [R8]
    (wrAcc && isReg(paddr, ADDR_BKPT_ADDR_HIGH)) |=> addrHigh_q == $past(wByte))
    else $error("Address high byte did not take the written value.");

  a_addr_low_write: assert property (@(posedge mclk) disable iff (srst) // [R8]
    (wrAcc && isReg(paddr, ADDR_BKPT_ADDR_LOW)) |=> addrLow_q == $past(wByte))
    else $error("Address low byte did not take the written value.");

  // Clearing break-active only loses against a match in the same cycle.
  a_active_clear: assert property (@(posedge mclk) disable iff (srst) // [R6]
    (wrAcc && isReg(paddr, ADDR_BKPT_STATUS_CTRL) && !wByte[BIT_BREAK_ACTIVE] && !addrHit) |=> !breakActive_q)
    else $error("Writing zero did not clear break-active.");

  a_wait_flag_set: assert property (@(posedge mclk) disable iff (srst) // [R12]
    irqEvents[IRQ_BIT_WAIT_EXIT] |=> exitedWait_q)
    else $error("Break out of wait did not set the exited-wait flag.");

  a_wait_flag_clear: assert property (@(posedge mclk) disable iff (srst) // [R13]
    (wrAcc && isReg(paddr, ADDR_SIM_BREAK_STATUS) && !wByte[BIT_EXITED_WAIT] && !irqEvents[IRQ_BIT_WAIT_EXIT])
    |=> !exitedWait_q)
    else $error("Writing zero did not clear the exited-wait flag.");

  // Stop mode alone must never disturb the programmed breakpoint.
  a_stop_regs_kept: assert property (@(posedge mclk) disable iff (srst) // [R14]
    (stopMode && !wrAcc) |=> $stable(addrHigh_q) && $stable(addrLow_q) && $stable(matchEnable_q))
    else $error("Break registers changed in stop mode.");

  c_match_break: cover property (@(posedge mclk) disable iff (srst) addrHit ##[1:20] breakInProgress);
  c_soft_break: cover property (@(posedge mclk) disable iff (srst) softBreak ##[1:20] breakInProgress);
  c_wait_exit: cover property (@(posedge mclk) disable iff (srst) $rose(exitedWait_q));
  c_last_cycle: cover property (@(posedge mclk) disable iff (srst) state_q == ST_RUN && addrHit && instrLastCycle);
  c_stop_blocked: cover property (@(posedge mclk) disable iff (srst)
    stopMode && matchEnable_q && cpuAddrValid && cpuAddr == {addrHigh_q, addrLow_q});

endmodule

// [core/brk_pkg.sv]
// Package with register map, field positions and constants of the address breakpoint unit.
package brk_pkg;
  localparam logic [15:0] ADDR_SIM_BREAK_STATUS    = 16'hFE00;
  localparam logic [15:0] ADDR_BREAK_FLAG_CLR_CTRL = 16'hFE03;
  localparam logic [15:0] ADDR_BKPT_ADDR_HIGH      = 16'hFE0C;
  localparam logic [15:0] ADDR_BKPT_ADDR_LOW       = 16'hFE0D;
  localparam logic [15:0] ADDR_BKPT_STATUS_CTRL    = 16'hFE0E;
  localparam logic [15:0] ADDR_IRQ_STATUS          = 16'hFE10;
  localparam logic [15:0] ADDR_IRQ_MASK            = 16'hFE14;
  localparam int          BIT_MATCH_ENABLE         = 7;
  localparam int          BIT_BREAK_ACTIVE         = 6;
  localparam int          BIT_EXITED_WAIT          = 1;
  localparam int          BIT_FLAG_CLEAR_EN        = 7;
  localparam int          IRQ_BIT_MATCH            = 0;
  localparam int          IRQ_BIT_SOFT             = 1;
  localparam int          IRQ_BIT_WAIT_EXIT        = 2;
  localparam logic [7:0]  RESET_BYTE               = 8'h00;
  localparam logic [2:0]  IRQ_RESET                = 3'h0;
  localparam logic [15:0] VEC_USER                 = 16'hFFFC;
  localparam logic [15:0] VEC_MONITOR              = 16'hFEFC;
  localparam logic [7:0]  SOFT_TRAP_OPCODE         = 8'h83;
  typedef enum logic [1:0] {ST_RUN, ST_PENDING, ST_BREAK} brk_state_e;
endpackage

// [verification/cpu_model.sv]
// Behavioural CPU sequencer: two-cycle instructions, break acceptance and a timed break handler.
`timescale 1ns/1ns
module cpu_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        breakInProgress,
  input  wire logic [7:0]  handlerLen,
  input  wire logic        rewindReturn,
  output logic [15:0]      cpuAddr,
  output logic             cpuAddrValid,
  output logic             instrLastCycle,
  output logic             instrBoundary,
  output logic             returnFromTrap
);
  logic [15:0] pc_q;
  logic        phase_q;
  logic [7:0]  cnt_q;

  // The program counter stands still while the break handler runs, except that a return pulse with rewindReturn steps it back by one.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_q    <= 16'h0000;
      phase_q <= 1'b0;
    end else if (!breakInProgress) begin
      phase_q <= ~phase_q;
      if (phase_q) pc_q <= pc_q + 16'h0001;
    end else if (returnFromTrap && rewindReturn) begin
      pc_q <= pc_q - 16'h0001;
    end
  end

  // The handler ends with a single return pulse after handlerLen cycles.
  always_ff @(posedge mclk) begin
    if (srst || !breakInProgress) begin
      cnt_q          <= 8'h00;
      returnFromTrap <= 1'b0;
    end else begin
      cnt_q          <= cnt_q + 8'h01;
      returnFromTrap <= (cnt_q == handlerLen) && !returnFromTrap;
    end
  end

  // An address that is not qualified shows the inverse, so no stale value can match.
  assign cpuAddrValid   = !breakInProgress;
  assign cpuAddr        = cpuAddrValid ? pc_q : ~pc_q;
  assign instrLastCycle = cpuAddrValid && phase_q;
  assign instrBoundary  = instrLastCycle;
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the address breakpoint unit driven over APB beside a CPU model.
`timescale 1ns/1ns
module tb_top
  import brk_pkg::*;
();
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb, strb;
  logic        cpuAddrValid, instrLastCycle, instrBoundary, returnFromTrap, breakRequest;
  logic        waitMode, stopMode, monitorMode, resetPinTestVoltage, rewindReturn;
  logic        breakInProgress, timerHalt, watchdogDisable, flagClearAllowed;
  logic [15:0] cpuAddr, trapVector, bp;
  logic [7:0]  trapOpcode, handlerLen;
  logic [32:0] expq[$];
  int          err_count, compares;
  logic [15:0] regs[7] = '{ADDR_SIM_BREAK_STATUS, ADDR_BREAK_FLAG_CLR_CTRL, ADDR_BKPT_ADDR_HIGH,
                           ADDR_BKPT_ADDR_LOW, ADDR_BKPT_STATUS_CTRL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};

  address_breakpoint_unit DUT (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cpuAddr, .cpuAddrValid, .instrLastCycle, .instrBoundary,
    .returnFromTrap, .waitMode, .stopMode, .monitorMode, .resetPinTestVoltage, .breakRequest,
    .trapOpcode, .trapVector, .breakInProgress, .timerHalt, .watchdogDisable, .flagClearAllowed, .irq);
  cpu_model cpu (.mclk, .srst, .breakInProgress, .handlerLen, .rewindReturn, .cpuAddr, .cpuAddrValid,
    .instrLastCycle, .instrBoundary, .returnFromTrap);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(logic [32:0] seen, logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(logic s, logic e);
    check({32'h0, s}, {32'h0, e});
  endtask

  task automatic xfer(logic w, logic [15:0] a, logic [7:0] d, logic [32:0] e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {14'h0000, a, 2'b00};
    pwdata  <= {24'h000000, d};
    pstrb   <= strb;
    if (!w) expq.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(logic [15:0] a, logic [7:0] d);
    xfer(1'b0, a, 8'h00, {25'h0, d});
  endtask

  // Read data is compared at the access edge against the oldest note.
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      check({pslverr, expq[0][32] ? 32'h0 : prdata}, expq[0]);
      void'(expq.pop_front());
    end
  end

  task automatic waitBrk(logic v);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (breakInProgress !== v && n < 300);
    chk1(breakInProgress, v);
  endtask

  task automatic arm();
    bp = cpuAddr + 16'(8 + $urandom_range(0, 7));
    wr(ADDR_BKPT_ADDR_HIGH, bp[15:8]);
    wr(ADDR_BKPT_ADDR_LOW, bp[7:0]);
    wr(ADDR_BKPT_STATUS_CTRL, 8'h80);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h84FAB924));
    {psel, penable, pwrite, waitMode, stopMode, monitorMode, resetPinTestVoltage, rewindReturn} = '0;
    paddr = '0;
    pwdata = '0;
    strb = 4'hF;
    pstrb = 4'hF;
    handlerLen = 8'd50;
    srst = 1'b1;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    xfer(1'b0, 16'hFE20, 8'h00, {1'b1, 32'h0});
    bp = 16'($urandom());
    wr(ADDR_BKPT_ADDR_HIGH, bp[15:8]);
    wr(ADDR_BKPT_ADDR_LOW, bp[7:0]);
    strb = 4'h0;
    wr(ADDR_BKPT_ADDR_HIGH, ~bp[15:8]);
    strb = 4'hF;
    rd(ADDR_BKPT_ADDR_HIGH, bp[15:8]);
    rd(ADDR_BKPT_ADDR_LOW, bp[7:0]);
    // A match during stop mode must not break and must leave the registers alone.
    @(posedge mclk);
    stopMode <= 1'b1;
    arm();
    repeat (60) @(negedge mclk);
    chk1(breakInProgress, 1'b0);
    rd(ADDR_BKPT_ADDR_LOW, bp[7:0]);
    rd(ADDR_BKPT_STATUS_CTRL, 8'h80);
    wr(ADDR_BKPT_STATUS_CTRL, 8'h00);
    rd(ADDR_BKPT_STATUS_CTRL, 8'h00);
    stopMode <= 1'b0;
    handlerLen <= 8'(40 + $urandom_range(0, 39));
    arm();
    waitBrk(1'b1);
    chk1(timerHalt, 1'b1);
    check({17'h0, trapVector}, {17'h0, VEC_USER});
    check({25'h0, trapOpcode}, {25'h0, SOFT_TRAP_OPCODE});
    chk1(flagClearAllowed, 1'b0);
    chk1(watchdogDisable, 1'b0);
    rd(ADDR_BKPT_STATUS_CTRL, 8'hC0);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    @(negedge mclk);
    chk1(irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 8'h01);
    @(negedge mclk);
    chk1(irq, 1'b0);
    wr(ADDR_BKPT_STATUS_CTRL, 8'h00);
    waitBrk(1'b0);
    chk1(timerHalt, 1'b0);
    // Soft break out of wait mode, in monitor mode, with test voltage and flag clearing on.
    @(posedge mclk);
    waitMode <= 1'b1;
    monitorMode <= 1'b1;
    resetPinTestVoltage <= 1'b1;
    wr(ADDR_BREAK_FLAG_CLR_CTRL, 8'h80);
    wr(ADDR_BKPT_STATUS_CTRL, 8'h40);
    waitBrk(1'b1);
    check({17'h0, trapVector}, {17'h0, VEC_MONITOR});
    chk1(watchdogDisable, 1'b1);
    chk1(flagClearAllowed, 1'b1);
    chk1(irq, 1'b0);
    rd(ADDR_SIM_BREAK_STATUS, 8'h02);
    rd(ADDR_IRQ_STATUS, 8'h06);
    // The handler saw exited-wait and steps the return address back by one.
    bp = ~cpuAddr;
    rewindReturn <= 1'b1;
    wr(ADDR_SIM_BREAK_STATUS, 8'h00);
    rd(ADDR_SIM_BREAK_STATUS, 8'h00);
    rd(ADDR_BREAK_FLAG_CLR_CTRL, 8'h80);
    wr(ADDR_BKPT_STATUS_CTRL, 8'h00);
    waitBrk(1'b0);
    check({17'h0, cpuAddr}, {17'h0, bp - 16'h0001});
    tally_and_finish();
  end
endmodule
